/* common/obct_pkg.sv */
// constants and shared types of the bitmap colour table and ping-pong block
// Notes on behaviour
// - RGB video window goes to YCbCr 4:2:2
// - RGB encoder mode gets 24-bit upsampled pixels
// - window 0 primary first, alternate when toggle clears
// - reverse bit inverts toggle sense
// - two bitmap windows rendered together
// - pixel indexes 256-entry 24-bit YUV table
// - depths 1, 2, 4, 8 bits
// - window B attribute mode alters window A
// - bitmap windows accept RGB565 pixels
// - RGB converted with the fixed matrix
// - two ROM tables, one RAM table
// - background and cursor from chosen entries
// - Cr/index write commits entry, busy shown
// - attenuation compresses luma 16-234, chroma 16-239
// - attribute mode suppresses attenuation
// - four RGB pixels in three words
// - red in lowest byte, blue highest
// - background index is eight bits
package obct_pkg;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned ENTRIES = 256;
	localparam logic ADDR_SEL_RESET = 1'b0;
	localparam logic TBL_RAM = 1'b1;
	localparam logic [2:0] MODE_1BPP = 3'h0;
	localparam logic [2:0] MODE_2BPP = 3'h1;
	localparam logic [2:0] MODE_4BPP = 3'h2;
	localparam logic [2:0] MODE_8BPP = 3'h3;
	localparam logic [2:0] MODE_RGB565 = 3'h4;
	localparam logic [1:0] CLS_BACKGROUND = 2'h0;
	localparam logic [1:0] CLS_CURSOR = 2'h1;
	localparam logic [1:0] CLS_BITMAP_A = 2'h2;
	localparam logic [1:0] CLS_BITMAP_B = 2'h3;
	localparam logic [7:0] COEF_YR = 8'h4d;
	localparam logic [7:0] COEF_YG = 8'h96;
	localparam logic [7:0] COEF_YB = 8'h1d;
	localparam logic [7:0] COEF_CBR = 8'h2b;
	localparam logic [7:0] COEF_CBG = 8'h55;
	localparam logic [7:0] COEF_CRG = 8'h6b;
	localparam logic [7:0] COEF_CRB = 8'h15;
	localparam logic [7:0] COEF_HALF = 8'h80;
	localparam logic [16:0] CHROMA_BIAS = 17'h0_8000;
	localparam logic [7:0] ATTN_FLOOR = 8'h10;
	localparam logic [7:0] ATTN_Y_SPAN = 8'hdb;
	localparam logic [7:0] ATTN_C_SPAN = 8'he0;

	typedef enum logic [1:0] {
		PH_W0 = 2'b00,
		PH_W1 = 2'b01,
		PH_W2 = 2'b10,
		PH_TAIL = 2'b11
	} obct_phase_t;

	typedef enum logic {
		WR_IDLE = 1'b0,
		WR_COMMIT = 1'b1
	} obct_wr_t;

	// fixed tables are stand-in ramps; real contents are mask data loaded at build
	function automatic logic [23:0] obct_rom_entry(input logic romSel, input logic [7:0] idx);
		obct_rom_entry = romSel ? {~idx, 8'h80, 8'h80} : {idx, 8'h80, 8'h80};
	endfunction
endpackage

/* common/obct_color_if.sv */
// colour converter connection between the block and its RGB-to-YCbCr stages
`timescale 1ns/1ns
interface obct_color_if;
	logic inValid;
	logic [7:0] red;
	logic [7:0] green;
	logic [7:0] blue;
	logic outValid;
	logic [23:0] ycc;
	modport conv (input inValid, input red, input green, input blue, output outValid, output ycc);
	modport user (output inValid, output red, output green, output blue, input outValid, input ycc);
endinterface

/* logic/obct_rgb2yuv.sv */
// one-cycle RGB to YCbCr converter
`timescale 1ns/1ns
module obct_rgb2yuv (
	input wire logic clock,
	input wire logic arst_n,
	obct_color_if.conv port
);
	import obct_pkg::*;
	typedef struct packed {
		logic valid;
		logic [23:0] ycc;
	} obct_conv_t;
	obct_conv_t s, next_s;
	logic [16:0] sumY, posCb, negCb, posCr, negCr, diffCb, diffCr;

	always_comb begin
		sumY = 17'(COEF_YR * port.red) + 17'(COEF_YG * port.green) + 17'(COEF_YB * port.blue);
		posCb = CHROMA_BIAS + 17'(COEF_HALF * port.blue);
		negCb = 17'(COEF_CBR * port.red) + 17'(COEF_CBG * port.green);
		posCr = CHROMA_BIAS + 17'(COEF_HALF * port.red);
		negCr = 17'(COEF_CRG * port.green) + 17'(COEF_CRB * port.blue);
		diffCb = posCb - negCb;
		diffCr = posCr - negCr;
		next_s.valid = port.inValid;
		next_s.ycc = {sumY[15:8], diffCb[15:8], diffCr[15:8]};
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign port.outValid = s.valid;
	assign port.ycc = s.ycc;
endmodule // obct_rgb2yuv

/* logic/obct_attenuate.sv */
// range compression of one YCbCr pixel
`timescale 1ns/1ns
module obct_attenuate (
	input wire logic enable,
	input wire logic [23:0] yccIn,
	output logic [23:0] yccOut
);
	import obct_pkg::*;
	logic [15:0] scY, scCb, scCr;

	always_comb begin
		scY = 16'(ATTN_Y_SPAN * yccIn[23:16]);
		scCb = 16'(ATTN_C_SPAN * yccIn[15:8]);
		scCr = 16'(ATTN_C_SPAN * yccIn[7:0]);
		if (enable) begin
			yccOut = {ATTN_FLOOR + scY[15:8], ATTN_FLOOR + scCb[15:8], ATTN_FLOOR + scCr[15:8]};
		end else begin
			yccOut = yccIn;
		end
	end
endmodule // obct_attenuate

/* logic/obct_top.sv */
// overlay colour path: video unpack and conversion, ping-pong, colour tables
`timescale 1ns/1ns
module obct_top (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic frameStart,
	input wire logic [obct_pkg::ADDR_W-1:0] win0PrimarySourceAddr,
	input wire logic [obct_pkg::ADDR_W-1:0] win0AlternateSourceAddr,
	input wire logic bufferToggle,
	input wire logic toggleSenseReverse,
	output logic [obct_pkg::ADDR_W-1:0] win0FetchAddr,
	output logic win0FetchAlternate,
	input wire logic rgbEnable,
	input wire logic rgbWindowSel,
	input wire logic vidWindow,
	input wire logic vidWordValid,
	input wire logic [31:0] vidWord,
	output logic vidWordReady,
	input wire logic encoderRgbMode,
	output logic vidOutValid,
	output logic [7:0] vidOutY,
	output logic [7:0] vidOutC,
	output logic vidOutChromaIsCr,
	output logic [23:0] vidOut444,
	input wire logic romTableSelect,
	input wire logic tableLumaCbWrite,
	input wire logic [7:0] tableLuma,
	input wire logic [7:0] tableCb,
	input wire logic tableCrIndexWrite,
	input wire logic [7:0] tableCr,
	input wire logic [7:0] tableEntryIndex,
	output logic tableWriteBusyFlag,
	input wire logic backgroundTableSelect,
	input wire logic [7:0] backgroundEntry,
	input wire logic cursorTableSelect,
	input wire logic [7:0] cursorEntry,
	input wire logic [2:0] bitmapAMode,
	input wire logic bitmapATableSelect,
	input wire logic bitmapAAttenuateEn,
	input wire logic [2:0] bitmapBMode,
	input wire logic bitmapBTableSelect,
	input wire logic bitmapBAttenuateEn,
	input wire logic bitmapBAttribute,
	input wire logic pixValid,
	input wire logic [1:0] pixClass,
	input wire logic [15:0] pixAData,
	input wire logic [15:0] pixBData,
	output logic colorValid,
	output logic [23:0] colorYcc
);
	import obct_pkg::*;

	typedef struct packed {
		logic addrSel;
		logic [ADDR_W-1:0] fetchAddr;
		obct_phase_t phase;
		logic [23:0] left;
		logic tailRgb;
		logic wordReady;
		logic v1Yuv;
		logic [15:0] v1Pix;
		logic vOdd;
		logic [7:0] heldCb;
		logic [7:0] heldCr;
		logic vOutValid;
		logic [7:0] vOutY;
		logic [7:0] vOutC;
		logic vOutIsCr;
		logic [23:0] vOut444;
		logic [7:0] holdLuma;
		logic [7:0] holdCb;
		logic [7:0] holdCr;
		logic [7:0] holdIndex;
		obct_wr_t wr;
		logic busy;
		logic [ENTRIES-1:0][23:0] ram;
		logic b1Valid;
		logic b1Use565;
		logic b1Atten;
		logic [23:0] b1Ycc;
		logic cValid;
		logic [23:0] cYcc;
	} obct_state_t;

	obct_state_t s, next_s;
	obct_color_if vidConv ();
	obct_color_if bmConv ();
	logic [23:0] attnOut;
	logic wordTaken, unpValid, unpRgb, useRam, attnEn, blankA;
	logic [23:0] unpPix;
	logic [7:0] idx;
	logic [2:0] pickMode;
	logic [15:0] pickData;

	// index taken from the top of a left-justified pixel chunk
	function automatic logic [7:0] bm_index(input logic [2:0] mode, input logic [15:0] data);
		case (mode)
			MODE_1BPP: bm_index = {7'h00, data[15]};
			MODE_2BPP: bm_index = {6'h00, data[15:14]};
			MODE_4BPP: bm_index = {4'h0, data[15:12]};
			default: bm_index = data[15:8];
		endcase
	endfunction

	function automatic logic [23:0] lookup(input logic ram, input logic romSel,
			input logic [7:0] entry, input logic [ENTRIES-1:0][23:0] table_q);
		lookup = ram ? table_q[entry] : obct_rom_entry(romSel, entry);
	endfunction

	obct_rgb2yuv vidConvUnit (
		.clock(clock),
		.arst_n(arst_n),
		.port(vidConv.conv)
	);

	obct_rgb2yuv bmConvUnit (
		.clock(clock),
		.arst_n(arst_n),
		.port(bmConv.conv)
	);

	obct_attenuate attnUnit (
		.enable(s.b1Atten),
		.yccIn(s.b1Use565 ? bmConv.ycc : s.b1Ycc),
		.yccOut(attnOut)
	);

	always_comb begin
		next_s = s;
		// ************************************************************
		// window 0 source address
		// ************************************************************
		// the fetch pointer only moves at a frame edge so no frame mixes buffers
		if (frameStart) begin
			next_s.addrSel = ~(bufferToggle ^ toggleSenseReverse);
			next_s.fetchAddr = next_s.addrSel ? win0AlternateSourceAddr
				: win0PrimarySourceAddr;
		end

		// ************************************************************
		// video word unpacking
		// ************************************************************
		wordTaken = vidWordValid & s.wordReady;
		unpValid = 1'b0;
		unpRgb = 1'b0;
		unpPix = 24'h00_0000;
		if (s.phase == PH_TAIL) begin
			unpValid = 1'b1;
			unpRgb = s.tailRgb;
			unpPix = s.left;
			next_s.phase = PH_W0;
		end else if (wordTaken) begin
			unpValid = 1'b1;
			unpRgb = rgbEnable & (rgbWindowSel == vidWindow);
			if (!unpRgb) begin
				unpPix = {8'h00, vidWord[15:0]};
				next_s.left = {8'h00, vidWord[31:16]};
				next_s.tailRgb = 1'b0;
				next_s.phase = PH_TAIL;
			end else begin
				case (s.phase)
					PH_W0: begin
						unpPix = vidWord[23:0];
						next_s.left = {16'h0000, vidWord[31:24]};
						next_s.phase = PH_W1;
					end
					PH_W1: begin
						unpPix = {vidWord[15:0], s.left[7:0]};
						next_s.left = {8'h00, vidWord[31:16]};
						next_s.phase = PH_W2;
					end
					default: begin
						unpPix = {vidWord[7:0], s.left[15:0]};
						next_s.left = vidWord[31:8];
						next_s.tailRgb = 1'b1;
						next_s.phase = PH_TAIL;
					end
				endcase
			end
		end
		// a word that yields two pixels stalls the source for one cycle
		next_s.wordReady = (next_s.phase != PH_TAIL);
		next_s.v1Yuv = unpValid & ~unpRgb;
		next_s.v1Pix = unpPix[15:0];

		// ************************************************************
		// 4:2:2 video output and 24-bit upsampling
		// ************************************************************
		next_s.vOutValid = 1'b0;
		if (vidConv.outValid) begin
			next_s.vOutValid = 1'b1;
			next_s.vOutY = vidConv.ycc[23:16];
			next_s.vOutC = s.vOdd ? vidConv.ycc[7:0] : vidConv.ycc[15:8];
			next_s.vOutIsCr = s.vOdd;
			next_s.vOdd = ~s.vOdd;
		end else if (s.v1Yuv) begin
			next_s.vOutValid = 1'b1;
			next_s.vOutY = s.v1Pix[7:0];
			next_s.vOutC = s.v1Pix[15:8];
			next_s.vOutIsCr = s.vOdd;
			next_s.vOdd = ~s.vOdd;
		end
		if (next_s.vOutValid) begin
			if (next_s.vOutIsCr) begin
				next_s.heldCr = next_s.vOutC;
			end else begin
				next_s.heldCb = next_s.vOutC;
			end
		end
		next_s.vOut444 = !encoderRgbMode ? 24'h00_0000 : next_s.vOutValid
			? {next_s.vOutY, next_s.heldCb, next_s.heldCr} : s.vOut444;

		// ************************************************************
		// RAM table loading
		// ************************************************************
		if (tableLumaCbWrite) begin
			next_s.holdLuma = tableLuma;
			next_s.holdCb = tableCb;
		end
		case (s.wr)
			WR_IDLE: begin
				// a second index write while busy is dropped
				if (tableCrIndexWrite) begin
					next_s.holdCr = tableCr;
					next_s.holdIndex = tableEntryIndex;
					next_s.busy = 1'b1;
					next_s.wr = WR_COMMIT;
				end
			end
			WR_COMMIT: begin
				next_s.ram[s.holdIndex] = {s.holdLuma, s.holdCb, s.holdCr};
				next_s.busy = 1'b0;
				next_s.wr = WR_IDLE;
			end
			default: begin
				next_s.wr = WR_IDLE;
				next_s.busy = 1'b0;
			end
		endcase

		// ************************************************************
		// bitmap, background and cursor colour
		// ************************************************************
		blankA = bitmapBAttribute & pixBData[14];
		useRam = 1'b0;
		attnEn = 1'b0;
		idx = 8'h00;
		pickMode = MODE_8BPP;
		pickData = pixAData;
		case (pixClass)
			CLS_BACKGROUND: begin
				useRam = (backgroundTableSelect == TBL_RAM);
				idx = backgroundEntry;
			end
			CLS_CURSOR: begin
				useRam = (cursorTableSelect == TBL_RAM);
				idx = cursorEntry;
			end
			CLS_BITMAP_A: begin
				pickMode = bitmapAMode;
				// attribute bits: top bit swaps table, next blanks to background
				useRam = (bitmapATableSelect == TBL_RAM)
					^ (bitmapBAttribute & pixBData[15]);
				idx = bm_index(bitmapAMode, pixAData);
				attnEn = bitmapAAttenuateEn & ~bitmapBAttribute;
				if (blankA) begin
					pickMode = MODE_8BPP;
					useRam = (backgroundTableSelect == TBL_RAM);
					idx = backgroundEntry;
				end
			end
			default: begin
				pickMode = bitmapBMode;
				pickData = pixBData;
				useRam = (bitmapBTableSelect == TBL_RAM);
				idx = bm_index(bitmapBMode, pixBData);
				attnEn = bitmapBAttenuateEn & ~bitmapBAttribute;
			end
		endcase
		next_s.b1Valid = pixValid & ~(bitmapBAttribute & (pixClass == CLS_BITMAP_B));
		next_s.b1Use565 = (pickMode == MODE_RGB565);
		next_s.b1Atten = attnEn;
		next_s.b1Ycc = lookup(useRam, romTableSelect, idx, s.ram);
		next_s.cValid = s.b1Valid;
		next_s.cYcc = attnOut;
		bmConv.inValid = pixValid & (pickMode == MODE_RGB565);
		bmConv.red = {pickData[15:11], pickData[15:13]};
		bmConv.green = {pickData[10:5], pickData[10:9]};
		bmConv.blue = {pickData[4:0], pickData[4:2]};
		vidConv.inValid = unpValid & unpRgb;
		vidConv.red = unpPix[7:0];
		vidConv.green = unpPix[15:8];
		vidConv.blue = unpPix[23:16];
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.addrSel <= ADDR_SEL_RESET;
			s.phase <= PH_W0;
			s.wr <= WR_IDLE;
			s.wordReady <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign win0FetchAddr = s.fetchAddr;
	assign win0FetchAlternate = s.addrSel;
	assign vidWordReady = s.wordReady;
	assign vidOutValid = s.vOutValid;
	assign vidOutY = s.vOutY;
	assign vidOutC = s.vOutC;
	assign vidOutChromaIsCr = s.vOutIsCr;
	assign vidOut444 = s.vOut444;
	assign tableWriteBusyFlag = s.busy;
	assign colorValid = s.cValid;
	assign colorYcc = s.cYcc;
endmodule // obct_top

/* tb/obct_props.sv */
// assertion checker bound to the overlay colour path top
`timescale 1ns/1ns
module obct_props (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic frameStart,
	input wire logic [obct_pkg::ADDR_W-1:0] win0PrimarySourceAddr,
	input wire logic [obct_pkg::ADDR_W-1:0] win0AlternateSourceAddr,
	input wire logic bufferToggle,
	input wire logic toggleSenseReverse,
	input wire logic [obct_pkg::ADDR_W-1:0] win0FetchAddr,
	input wire logic win0FetchAlternate,
	input wire logic rgbEnable,
	input wire logic rgbWindowSel,
	input wire logic vidWindow,
	input wire logic vidWordValid,
	input wire logic vidWordReady,
	input wire logic encoderRgbMode,
	input wire logic [23:0] vidOut444,
	input wire logic tableCrIndexWrite,
	input wire logic tableWriteBusyFlag,
	input wire logic bitmapBAttribute,
	input wire logic pixValid,
	input wire logic [1:0] pixClass,
	input wire logic colorValid
);
	import obct_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	// ****
	// properties
	// ****
	sequence s_busyPulse;
		tableWriteBusyFlag ##1 !tableWriteBusyFlag;
	endsequence
	sequence s_attrPix;
		pixValid && bitmapBAttribute && pixClass == CLS_BITMAP_B;
	endsequence
	property p_pingSel;
		frameStart |=> win0FetchAlternate == !($past(bufferToggle) ^ $past(toggleSenseReverse))
			&& win0FetchAddr == (win0FetchAlternate ? $past(win0AlternateSourceAddr)
			: $past(win0PrimarySourceAddr));
	endproperty
	a_pingSel: assert property (p_pingSel) else $error("wrong buffer after frame start");
	property p_pingHold;
		!frameStart |=> $stable(win0FetchAlternate) && $stable(win0FetchAddr);
	endproperty
	a_pingHold: assert property (p_pingHold) else $error("fetch moved mid frame");
	property p_busy;
		tableCrIndexWrite && !tableWriteBusyFlag |=> s_busyPulse;
	endproperty
	a_busy: assert property (p_busy) else $error("busy pulse wrong");
	property p_busyCause;
		$rose(tableWriteBusyFlag) |-> $past(tableCrIndexWrite);
	endproperty
	a_busyCause: assert property (p_busyCause) else $error("busy without commit");
	property p_color;
		pixValid && !(bitmapBAttribute && pixClass == CLS_BITMAP_B) |-> ##2 colorValid;
	endproperty
	a_color: assert property (p_color) else $error("colour result missing");
	property p_colorCause;
		colorValid |-> $past(pixValid, 2);
	endproperty
	a_colorCause: assert property (p_colorCause) else $error("colour without pixel");
	property p_attrDrop;
		s_attrPix |-> ##2 !colorValid;
	endproperty
	a_attrDrop: assert property (p_attrDrop) else $error("attribute pixel shown");
	property p_rgbOff;
		(!encoderRgbMode) [*2] |-> vidOut444 == 24'h00_0000;
	endproperty
	a_rgbOff: assert property (p_rgbOff) else $error("wide pixel while off");
	// a packed word carries two pixels, so the source must see one idle cycle
	property p_readyGap;
		vidWordValid && vidWordReady && !(rgbEnable && rgbWindowSel == vidWindow)
			|=> !vidWordReady ##1 vidWordReady;
	endproperty
	a_readyGap: assert property (p_readyGap) else $error("stall after packed word wrong");
endmodule // obct_props

bind obct_top obct_props u_props (.*);

/* tb/obct_sdram_model.sv */
// behavioural frame memory offering video words to the block
`timescale 1ns/1ns
module obct_sdram_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic stall,
	input wire logic vidWordReady,
	output logic vidWordValid,
	output logic [31:0] vidWord
);
	logic [31:0] q[$];

	task automatic push(input logic [31:0] w);
		q.push_back(w);
	endtask

	// an offer holds until taken; idle bus flips so stale data never looks valid
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			vidWordValid <= 1'b0;
			vidWord <= 32'h0000_0000;
		end else if (!vidWordValid || vidWordReady) begin
			if (vidWordValid)
				q.delete(0);
			if (q.size() > 0 && !stall) begin
				vidWordValid <= 1'b1;
				vidWord <= q[0];
			end else begin
				vidWordValid <= 1'b0;
				vidWord <= ~vidWord;
			end
		end
	end
endmodule // obct_sdram_model

/* tb/obct_tb_top.sv */
// self-checking bench for the overlay colour path top
`timescale 1ns/1ns
module obct_tb_top;
	import obct_pkg::*;
	logic clock, arst_n, frameStart, bufferToggle, toggleSenseReverse, rgbEnable, rgbWindowSel;
	logic vidWindow, encoderRgbMode, romTableSelect, tableLumaCbWrite, tableCrIndexWrite;
	logic backgroundTableSelect, cursorTableSelect, bitmapATableSelect, bitmapAAttenuateEn;
	logic bitmapBTableSelect, bitmapBAttenuateEn, bitmapBAttribute, pixValid, stall;
	logic win0FetchAlternate, vidWordValid, vidWordReady, vidOutValid, vidOutChromaIsCr;
	logic tableWriteBusyFlag, colorValid;
	logic [31:0] win0PrimarySourceAddr, win0AlternateSourceAddr, win0FetchAddr, vidWord, w;
	logic [7:0] tableLuma, tableCb, tableCr, tableEntryIndex, backgroundEntry, cursorEntry;
	logic [7:0] vidOutY, vidOutC, y, cb, cr, e;
	logic [7:0] g[4];
	logic [2:0] bitmapAMode, bitmapBMode;
	logic [1:0] pixClass;
	logic [15:0] pixAData, pixBData;
	logic [23:0] vidOut444, colorYcc;
	logic [40:0] vq[$];
	int err_count = 0;
	int checked = 0;
	int seed = 60011;

	obct_top dut (.*);
	obct_sdram_model mem (
		.clock(clock),
		.arst_n(arst_n),
		.stall(stall),
		.vidWordReady(vidWordReady),
		.vidWordValid(vidWordValid),
		.vidWord(vidWord)
	);

	always #4 clock = ~clock;

	always @(posedge clock)
		if (vidOutValid === 1'b1)
			vq.push_back({vidOut444, vidOutChromaIsCr, vidOutC, vidOutY});

	// ****
	// helpers
	// ****
	function automatic logic [23:0] rom(input logic s, input logic [7:0] i);
		return {s ? ~i : i, 16'h8080};
	endfunction

	function automatic logic [7:0] atn(input logic [7:0] v, input logic [7:0] s);
		return ATTN_FLOOR + 8'((16'(v) * 16'(s)) >> 8);
	endfunction

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic pix(input logic [1:0] c, input logic [15:0] a, input logic [15:0] b,
			input logic want, input logic [23:0] exp);
		@(posedge clock);
		pixClass <= c;
		pixAData <= a;
		pixBData <= b;
		pixValid <= 1'b1;
		@(posedge clock);
		pixValid <= 1'b0;
		#1;
		for (int k = 0; k < 4 && colorValid !== 1'b1; k++) begin
			@(posedge clock);
			#1;
		end
		chk({colorValid, colorYcc & {24{want}}}, {want, exp});
	endtask

	// ****
	// scenarios
	// ****
	initial begin
		{clock, arst_n, frameStart, bufferToggle, toggleSenseReverse, rgbEnable} = '0;
		{rgbWindowSel, vidWindow, encoderRgbMode, romTableSelect, tableLumaCbWrite} = '0;
		{tableCrIndexWrite, backgroundTableSelect, cursorTableSelect, bitmapATableSelect} = '0;
		{bitmapAAttenuateEn, bitmapBTableSelect, bitmapBAttenuateEn, bitmapBAttribute} = '0;
		{pixValid, stall, tableLuma, tableCb, tableCr, tableEntryIndex, backgroundEntry} = '0;
		{cursorEntry, bitmapAMode, bitmapBMode, pixClass, pixAData, pixBData} = '0;
		win0PrimarySourceAddr = $random(seed);
		win0AlternateSourceAddr = $random(seed);
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			bufferToggle <= i[1];
			toggleSenseReverse <= i[0];
			frameStart <= 1'b1;
			@(posedge clock);
			frameStart <= 1'b0;
			bufferToggle <= !i[1];
			@(posedge clock);
			#1;
			chk(win0FetchAlternate, !(i[1] ^ i[0]));
			w = (i[1] ^ i[0]) ? win0PrimarySourceAddr : win0AlternateSourceAddr;
			chk(win0FetchAddr, w);
		end
		@(posedge clock);
		rgbEnable <= 1'b1;
		vidWindow <= 1'b1;
		w = {8'h80, 24'($random(seed))};
		mem.push(w);
		for (int t = 0; t < 60 && vq.size() < 2; t++) @(posedge clock);
		chk(vq.pop_front(), {25'h0, w[15:0]});
		chk(vq.pop_front(), {25'h1, w[31:16]});
		foreach (g[k]) g[k] = $random(seed);
		@(posedge clock);
		rgbWindowSel <= 1'b1;
		encoderRgbMode <= 1'b1;
		stall <= 1'b1;
		mem.push({g[1], g[0], g[0], g[0]});
		mem.push({g[2], g[2], g[1], g[1]});
		mem.push({g[3], g[3], g[3], g[2]});
		repeat (4) @(posedge clock);
		stall <= 1'b0;
		for (int t = 0; t < 60 && vq.size() < 4; t++) @(posedge clock);
		for (int k = 0; k < 4; k++)
			chk(vq.pop_front(), {g[k], 16'h8080, k[0], 8'h80, g[k]});
		{e, y, cb, cr} = $random(seed);
		for (int k = 0; k < 8 && tableWriteBusyFlag !== 1'b0; k++) @(posedge clock);
		@(posedge clock);
		{tableLuma, tableCb, tableLumaCbWrite} <= {y, cb, 1'b1};
		@(posedge clock);
		{tableLumaCbWrite, tableCr, tableEntryIndex, tableCrIndexWrite} <= {1'b0, cr, e, 1'b1};
		@(posedge clock);
		tableCrIndexWrite <= 1'b0;
		#1;
		chk(tableWriteBusyFlag, 1'b1);
		@(posedge clock);
		#1;
		chk(tableWriteBusyFlag, 1'b0);
		@(posedge clock);
		{backgroundTableSelect, backgroundEntry, cursorEntry} <= {1'b1, e, e};
		pix(CLS_BACKGROUND, 16'h0, 16'h0, 1'b1, {y, cb, cr});
		for (int r = 0; r < 2; r++) begin
			@(posedge clock);
			romTableSelect <= r[0];
			pix(CLS_CURSOR, 16'h0, 16'h0, 1'b1, rom(r[0], e));
		end
		for (int m = 0; m < 4; m++) begin
			w = $random(seed);
			@(posedge clock);
			bitmapAMode <= m[2:0];
			bitmapBMode <= m[2:0];
			pix(CLS_BITMAP_A, w[15:0], w[31:16], 1'b1, rom(1'b1, w[15:8] >> (8 - (1 << m))));
			pix(CLS_BITMAP_B, w[15:0], w[31:16], 1'b1, rom(1'b1, w[31:24] >> (8 - (1 << m))));
		end
		@(posedge clock);
		bitmapAMode <= MODE_RGB565;
		w[4:0] = {{3{w[0]}}, w[2:1]};
		g[0] = {w[4:0], {3{w[4]}}};
		pix(CLS_BITMAP_A, {w[4:0], w[4:0], w[4], w[4:0]}, 16'h0, 1'b1, {g[0], 16'h8080});
		pix(CLS_BITMAP_A, 16'hffff, 16'h0, 1'b1, 24'hff_8080);
		@(posedge clock);
		bitmapAMode <= MODE_8BPP;
		{bitmapATableSelect, bitmapBTableSelect, bitmapAAttenuateEn, bitmapBAttenuateEn} <= 4'hf;
		w[23:0] = {atn(y, ATTN_Y_SPAN), atn(cb, ATTN_C_SPAN), atn(cr, ATTN_C_SPAN)};
		pix(CLS_BITMAP_A, {e, 8'h00}, 16'h0, 1'b1, w[23:0]);
		pix(CLS_BITMAP_B, 16'h0, {e, 8'h00}, 1'b1, w[23:0]);
		@(posedge clock);
		bitmapBAttribute <= 1'b1;
		pix(CLS_BITMAP_A, {e, 8'h00}, 16'h0, 1'b1, {y, cb, cr});
		pix(CLS_BITMAP_A, {e, 8'h00}, 16'h8000, 1'b1, rom(1'b1, e));
		pix(CLS_BITMAP_B, 16'h0, {e, 8'h00}, 1'b0, 24'h00_0000);
		pix(CLS_BITMAP_A, {~e, 8'h00}, 16'h4000, 1'b1, {y, cb, cr});
		@(posedge clock);
		encoderRgbMode <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk(vidOut444, 24'h00_0000);
		tally_and_finish();
	end

	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule // obct_tb_top
